/* File: hdl/smfl_defines.vh */
`ifndef SMFL_DEFINES_VH
`define SMFL_DEFINES_VH
`define SMFL_CTRL_ADDR 8'hdf
`define SMFL_CTRL_RESET 8'hde
`define SMFL_BIT_DOK 7
`define SMFL_BIT_AOK 6
`define SMFL_BIT_FLAG 5
`define SMFL_BIT_DTRIP_HI 4
`define SMFL_BIT_DTRIP_LO 3
`define SMFL_BIT_ATRIP_HI 2
`define SMFL_BIT_ATRIP_LO 1
`define SMFL_BIT_EN 0
`define SMFL_TRIP_463 2'h0
`define SMFL_TRIP_308 2'h1
`define SMFL_TRIP_293 2'h2
`define SMFL_TRIP_263 2'h3
`define SMFL_QUAL_MS 250
`define SMFL_CLK_KHZ 200000
`define SMFL_GLITCH_CYCLES 16
`define SMFL_GLITCH_CW 5
`define SMFL_QUAL_CW 26
`define SMFL_SYNC_RESET 2'h3
`define SMFL_DTRIP_RESET 2'h3
`define SMFL_ATRIP_RESET 2'h3
`define SMFL_EN_RESET 1'h0
`define SMFL_FLAG_RESET 1'h0
`endif

/* File: hdl/smfl_glitch_filter.v */
`timescale 1ns/1ps
`default_nettype none
module smfl_glitch_filter #(
  parameter CYCLES = 16,
  parameter CW = 5
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Synchronised level in, filtered level out
  input wire sync_in,
  output reg filt_q
);
  reg [CW-1:0] cnt_q;
  // Output moves only after the input held a new level for CYCLES clocks
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= {CW{1'b0}};
      filt_q <= 1'b1;
    end else if (sync_in == filt_q) begin
      cnt_q <= {CW{1'b0}};
    end else if (cnt_q == CYCLES[CW-1:0] - 1'b1) begin
      cnt_q <= {CW{1'b0}};
      filt_q <= sync_in;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/smfl_supply_monitor.v */
// Functional notes
// (R01) Flag low supply when enabled, either comparator
// (R02) Interrupt request gated by external enable
// (R03) Bit 7 reads live digital comparator
// (R04) Bit 6 reads live analog comparator
// (R05) Flag bit 5 set while comparator low
// (R06) Flag clears after 250 ms good supply
// (R07) Software clear ignored while comparator low
// (R08) Glitches on comparators are filtered out
// (R09) Digital trip select in bits 4:3
// (R10) Digital trip encoding 4.63/3.08/2.93/2.63 V
// (R11) Analog trip select bits 2:1, same encoding
// (R12) Bit 0 enables monitoring
// (R13) Relapse restarts full qualification interval
// (R14) Interval counted in core clock cycles
`include "smfl_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module smfl_supply_monitor #(
  parameter QUAL_CYCLES = `SMFL_QUAL_MS * `SMFL_CLK_KHZ,
  parameter QW = `SMFL_QUAL_CW,
  parameter GLITCH_CYCLES = `SMFL_GLITCH_CYCLES
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Special-function register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  // Analog comparators, asynchronous
  input wire digital_cmp_raw,
  input wire analog_cmp_raw,
  // Trip selections and enable to the comparators
  output wire [1:0] digital_trip_sel,
  output wire [1:0] analog_trip_sel,
  output wire monitor_en,
  // Interrupt
  input wire secondary_irq_enable_prio,
  output wire low_supply_irq
);
  localparam NCH = 2;
  localparam CH_D = 0;
  localparam CH_A = 1;
  localparam GW = `SMFL_GLITCH_CW;

  // Channel vectors, index 0 digital and 1 analog
  wire [NCH-1:0] cmp_raw;
  wire [NCH-1:0] supply_ok;
  wire digital_supply_ok;
  wire analog_supply_ok;

  // Control fields
  reg [1:0] dtrip_q;
  reg [1:0] dtrip_d;
  reg [1:0] atrip_q;
  reg [1:0] atrip_d;
  reg en_q;
  reg en_d;

  // Flag and qualification counter
  reg low_supply_irq_flag_q;
  reg low_supply_irq_flag_d;
  reg [QW-1:0] qual_q;
  reg [QW-1:0] qual_d;

  // Read path
  reg [7:0] rdata_d;

  wire both_ok;
  wire wr_hit;
  wire rd_hit;
  wire qual_done;

  // Address decode, shared by write and read paths
  function addr_hit;
    input [7:0] addr;
    begin
      addr_hit = (addr == `SMFL_CTRL_ADDR);
    end
  endfunction

  assign cmp_raw[CH_D] = digital_cmp_raw;
  assign cmp_raw[CH_A] = analog_cmp_raw;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_chan
      reg [1:0] sync_q;

      // Comparator edges are asynchronous to mclk
      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          sync_q <= `SMFL_SYNC_RESET;
        end else begin
          sync_q <= {sync_q[0], cmp_raw[ch]};
        end
      end

      // Costs GLITCH_CYCLES of latency on every real drop
      smfl_glitch_filter #(
        .CYCLES(GLITCH_CYCLES),
        .CW(GW)
      ) smfl_glitch_filter_inst ( // [R08]
        .mclk(mclk),
        .rst(rst),
        .sync_in(sync_q[1]),
        .filt_q(supply_ok[ch])
      );
    end
  endgenerate

  assign digital_supply_ok = supply_ok[CH_D];
  assign analog_supply_ok = supply_ok[CH_A];

  assign wr_hit = sfr_wr && addr_hit(sfr_addr);
  assign rd_hit = addr_hit(sfr_addr);
  assign both_ok = digital_supply_ok && analog_supply_ok;
  assign qual_done = (qual_q == QUAL_CYCLES[QW-1:0] - 1'b1); // [R14]

  // Control register next state
  always @* begin
    dtrip_d = dtrip_q;
    atrip_d = atrip_q;
    en_d = en_q;
    if (wr_hit) begin
      dtrip_d = sfr_wdata[`SMFL_BIT_DTRIP_HI:`SMFL_BIT_DTRIP_LO]; // [R09]
      atrip_d = sfr_wdata[`SMFL_BIT_ATRIP_HI:`SMFL_BIT_ATRIP_LO]; // [R11]
      en_d = sfr_wdata[`SMFL_BIT_EN]; // [R12]
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      dtrip_q <= `SMFL_DTRIP_RESET;
      atrip_q <= `SMFL_ATRIP_RESET;
      en_q <= `SMFL_EN_RESET;
    end else begin
      dtrip_q <= dtrip_d;
      atrip_q <= atrip_d;
      en_q <= en_d;
    end
  end

  // Flag: hardware set beats any software write
  always @* begin
    low_supply_irq_flag_d = low_supply_irq_flag_q;
    qual_d = qual_q;
    if (!en_q) begin
      // Disabled: software owns the flag, counter idle
      qual_d = {QW{1'b0}}; // [R12]
      if (wr_hit) begin
        low_supply_irq_flag_d = sfr_wdata[`SMFL_BIT_FLAG];
      end
    end else if (!both_ok) begin
      low_supply_irq_flag_d = 1'b1; // [R01] [R05] [R07]
      qual_d = {QW{1'b0}}; // [R13]
    end else if (wr_hit) begin
      // Software write restarts qualification either way
      low_supply_irq_flag_d = sfr_wdata[`SMFL_BIT_FLAG];
      qual_d = {QW{1'b0}};
    end else if (low_supply_irq_flag_q) begin
      if (qual_done) begin
        low_supply_irq_flag_d = 1'b0; // [R06]
        qual_d = {QW{1'b0}};
      end else begin
        qual_d = qual_q + 1'b1; // [R06] [R14]
      end
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_supply_irq_flag_q <= `SMFL_FLAG_RESET;
      qual_q <= {QW{1'b0}};
    end else begin
      low_supply_irq_flag_q <= low_supply_irq_flag_d;
      qual_q <= qual_d;
    end
  end

  // Read data; comparator bits live through the filter
  always @* begin
    rdata_d = 8'h00;
    if (rd_hit) begin
      rdata_d[`SMFL_BIT_DOK] = digital_supply_ok; // [R03]
      rdata_d[`SMFL_BIT_AOK] = analog_supply_ok; // [R04]
      rdata_d[`SMFL_BIT_FLAG] = low_supply_irq_flag_q; // [R05]
      rdata_d[`SMFL_BIT_DTRIP_HI] = dtrip_q[1];
      rdata_d[`SMFL_BIT_DTRIP_LO] = dtrip_q[0];
      rdata_d[`SMFL_BIT_ATRIP_HI] = atrip_q[1];
      rdata_d[`SMFL_BIT_ATRIP_LO] = atrip_q[0];
      rdata_d[`SMFL_BIT_EN] = en_q;
    end
  end

  // Registered so reads see one settled value per cycle
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= `SMFL_CTRL_RESET;
    end else begin
      sfr_rdata <= rdata_d;
    end
  end

  assign digital_trip_sel = dtrip_q; // [R10]
  assign analog_trip_sel = atrip_q; // [R11]
  assign monitor_en = en_q;
  assign low_supply_irq = low_supply_irq_flag_q && secondary_irq_enable_prio; // [R02]
endmodule
`default_nettype wire

/* File: test/smfl_chk_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module smfl_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Supplies, controls, interrupt
  input wire logic digital_cmp_raw,
  input wire logic analog_cmp_raw,
  input wire logic [1:0] digital_trip_sel,
  input wire logic [1:0] analog_trip_sel,
  input wire logic monitor_en,
  input wire logic secondary_irq_enable_prio,
  input wire logic low_supply_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence wr_ctl;
    sfr_wr && sfr_addr == 8'hdf;
  endsequence
  // Low for 24 cycles outlasts sync plus filter delay
  sequence d_low8;
    (!digital_cmp_raw && monitor_en && sfr_addr == 8'hdf)[*8];
  endsequence
  sequence a_low8;
    (!analog_cmp_raw && monitor_en && sfr_addr == 8'hdf)[*8];
  endsequence
  AST_IRQ_GATE: assert property (low_supply_irq |-> secondary_irq_enable_prio)
    else $error("irq without enable");
  AST_EN_WR: assert property (wr_ctl |=> monitor_en == $past(sfr_wdata[0]))
    else $error("enable not written");
  AST_DTRIP: assert property (wr_ctl |=> digital_trip_sel == $past(sfr_wdata[4:3]))
    else $error("digital trip not written");
  AST_ATRIP: assert property (wr_ctl |=> analog_trip_sel == $past(sfr_wdata[2:1]))
    else $error("analog trip not written");
  AST_HOLD: assert property (!sfr_wr |=> $stable({digital_trip_sel, analog_trip_sel, monitor_en}))
    else $error("control changed without write");
  AST_RD_CTL: assert property (wr_ctl ##1 sfr_addr == 8'hdf |=> sfr_rdata[4:0] == $past(sfr_wdata[4:0], 2))
    else $error("control readback wrong");
  AST_DLOW: assert property (d_low8 ##1 d_low8 ##1 d_low8 |-> !sfr_rdata[7] && sfr_rdata[5])
    else $error("digital low not flagged");
  AST_ALOW: assert property (a_low8 ##1 a_low8 ##1 a_low8 |-> sfr_rdata[6:5] == 2'h1)
    else $error("analog low not flagged");
endmodule
`default_nettype wire

/* File: test/smfl_supply_monitor_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module smfl_supply_monitor_tb;
  logic mclk = 1'h0, rst = 1'h1, sfr_wr = 1'h0, digital_cmp_raw = 1'h1, analog_cmp_raw = 1'h1;
  logic secondary_irq_enable_prio = 1'h0, low_supply_irq, monitor_en;
  logic [7:0] sfr_addr = 8'hdf, sfr_wdata = 8'h00, sfr_rdata, d;
  logic [1:0] digital_trip_sel, analog_trip_sel;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  smfl_supply_monitor #(.QUAL_CYCLES(100)) smfl_supply_monitor_inst (.*);
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  function automatic logic [7:0] ex(logic dk, logic ak, logic f, logic [4:0] c);
    return {dk, ak, f, c};
  endfunction
  task chk(logic [7:0] got, logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(logic [7:0] v, logic s);
    @(posedge mclk);
    sfr_wr <= 1'h1;
    sfr_wdata <= v;
    secondary_irq_enable_prio <= s;
    @(posedge mclk);
    sfr_wr <= 1'h0;
    @(posedge mclk);
    #1;
  endtask
  task cmp(logic dk, logic ak, int n);
    @(posedge mclk);
    digital_cmp_raw <= dk;
    analog_cmp_raw <= ak;
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h23d5));
    repeat (20) @(posedge mclk);
    chk(sfr_rdata, 8'hde);
    rst <= 1'h0;
    for (int i = 0; i < 10; i++) begin
      d = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($urandom);
      wr(d, d[7]);
      chk(sfr_rdata, ex(1'h1, 1'h1, d[5], d[4:0]));
      chk({low_supply_irq, 2'h0, digital_trip_sel, analog_trip_sel, monitor_en}, {d[7] & d[5], 2'h0, d[4:0]});
    end
    $display("register test done");
    wr(8'h01, 1'h1);
    cmp(1'h0, 1'h1, 30);
    wr(8'h01, 1'h1);
    chk(sfr_rdata, ex(1'h0, 1'h1, 1'h1, 5'h01));
    chk({7'h00, low_supply_irq}, 8'h01);
    cmp(1'h1, 1'h1, 70);
    cmp(1'h1, 1'h0, 30);
    cmp(1'h1, 1'h1, 70);
    chk(sfr_rdata, ex(1'h1, 1'h1, 1'h1, 5'h01));
    cmp(1'h1, 1'h1, 80);
    chk(sfr_rdata, ex(1'h1, 1'h1, 1'h0, 5'h01));
    cmp(1'h0, 1'h0, 10);
    cmp(1'h1, 1'h1, 30);
    chk(sfr_rdata, ex(1'h1, 1'h1, 1'h0, 5'h01));
    cmp(1'h1, 1'h0, 30);
    chk(sfr_rdata, ex(1'h1, 1'h0, 1'h1, 5'h01));
    $display("supply test done");
    stop_test();
  end
endmodule
bind smfl_supply_monitor smfl_chk smfl_chk_inst (.*);
`default_nettype wire
